// File: verilog/tick_pkg.sv
// Purpose: Shared constants for the system tick down counter
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes:   Offsets are byte addresses within the block
package tick_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] off_ctrl_status = 8'h00;
   localparam logic [7:0] off_reload      = 8'h04;
   localparam logic [7:0] off_current     = 8'h08;
   localparam logic [7:0] off_calib       = 8'h0c;
   localparam logic [7:0] off_irq_status  = 8'h10;
   localparam logic [7:0] off_irq_mask    = 8'h14;
   localparam int addr_w = 8;

   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int bit_enable  = 0;
   localparam int bit_tick_interrupt_enable = 1;
   localparam int bit_clksel  = 2;
   localparam int bit_wrap    = 16;
   localparam int bit_no_reference_clock   = 31;
   localparam int bit_inexact = 30;
   localparam int count_w     = 24;
   localparam int irq_w       = 2;
   localparam int irq_wrap    = 0;
   localparam int irq_cvwrite = 1;

   // ------------------------------------------------------------
   // Reset and fixed values
   // ------------------------------------------------------------
   localparam logic [23:0] count_zero    = 24'h000000;
   localparam logic [23:0] count_one     = 24'h000001;
   localparam logic [23:0] calib_count   = 24'h000000;
   localparam logic [1:0]  irq_none      = 2'h0;
   localparam logic [31:0] word_zero     = 32'h00000000;
endpackage

// File: verilog/tick_sync.sv
// Purpose: Three-stage synchroniser for asynchronous level inputs
// Assumes: One destination clock
// Notes:   Output changes once stages two and three agree
module tick_sync
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   output logic      dout
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic o;
   } sync_s;

   sync_s st_r;
   sync_s st_nxt;

   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3)
      begin
         st_nxt.o = st_r.s3;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.o;
endmodule

// File: verilog/tick_counter.sv
// Purpose: 24-bit down counter core with reload and zero event
// Assumes: Enables come from the same clock domain
// Notes:   Event only on a 1 to 0 transition
module tick_counter
#(
   parameter int width = 24
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             run,
   input  wire logic             clear,
   input  wire logic [width-1:0] reload,
   output logic      [width-1:0] count,
   output logic                  hit_zero
);
   typedef struct packed
   {
      logic [width-1:0] cnt;
      logic             pend;
      logic             hit;
   } cnt_s;

   cnt_s st_r;
   cnt_s st_nxt;

   always_comb
   begin
      st_nxt     = st_r;
      st_nxt.hit = 1'b0;
      if (clear)
      begin
         st_nxt.cnt  = '0;
         st_nxt.pend = 1'b1;
      end
      else if (run)
      begin
         if (st_r.cnt == '0)
         begin
            st_nxt.cnt  = reload;
            st_nxt.pend = 1'b0;
         end
         else
         begin
            st_nxt.cnt = st_r.cnt - 1'b1;
            if (st_r.cnt == width'(1))
            begin
               st_nxt.hit = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign count    = st_r.cnt;
   assign hit_zero = st_r.hit;
endmodule

// File: verilog/system_tick_down_counter.sv
// Purpose: System tick down counter with APB register access
// Assumes: pclk is the gated interrupt controller clock, 25 MHz
// Notes:   Debug halt and clock gate inputs are asynchronous pins
//
// How it works
// - Wrap flag at bit 16 sets on zero reach, clears on read
// - Clock select bit 2 always reads one, writes ignored
// - Tick interrupt enable bit 1 gates the tick exception request
// - Bit 0 enables counting
// - Reload holds 24 bits; loaded when enabled and on zero
// - Flag and exception only on a transition from one to zero
// - Period is reload plus one cycles
// - Current value read returns the live count
// - Any current value write with a byte strobe set clears count, and wrap flag unless hit_zero sets it that cycle
// - Calibration bit 31 reads one, no reference clock
// - Calibration bit 30 reads one, count inexact
// - Calibration count field reads zero
// - Counter stops while its clock is stopped
// - After zero, load reload next edge, then decrement
// - Current value write raises no exception, reloads next clock
// - Counter holds while processor is halted for debug
//
// The implementer's own choices: register access over APB and the register addresses.
module system_tick_down_counter
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        debug_halt,
   input  wire logic        clock_stopped,
   output logic             tick_request,
   output logic             irq
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic                       enable;
      logic                       tick_interrupt_enable;
      logic                       wrap_flag;
      logic [tick_pkg::count_w-1:0] reload;
      logic                       req;
      logic [tick_pkg::irq_w-1:0] irq_stat;
      logic [tick_pkg::irq_w-1:0] irq_mask;
      logic                       irq;
      logic [31:0]                rdata;
      logic                       ready;
      logic                       err;
   } regs_s;

   regs_s st_r;
   regs_s st_nxt;

   logic                         halt_s;
   logic                         stop_s;
   logic [tick_pkg::count_w-1:0] count;
   logic                         hit_zero;
   logic                         run;
   logic                         cv_write;
   logic                         access;
   logic                         wr;
   logic                         rd;
   logic [tick_pkg::addr_w-1:0]  addr;
   logic                         mapped;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   tick_sync u_halt
   (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (debug_halt),
      .dout    (halt_s)
   );

   tick_sync u_stop
   (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (clock_stopped),
      .dout    (stop_s)
   );

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign access   = psel && penable && !st_r.ready;
   assign wr       = access && pwrite;
   assign rd       = access && !pwrite;
   assign addr     = paddr[tick_pkg::addr_w-1:0];
   assign mapped   = (addr == tick_pkg::off_ctrl_status) || (addr == tick_pkg::off_reload)
                  || (addr == tick_pkg::off_current) || (addr == tick_pkg::off_calib)
                  || (addr == tick_pkg::off_irq_status) || (addr == tick_pkg::off_irq_mask);
   assign cv_write = wr && (addr == tick_pkg::off_current) && (pstrb != 4'h0);
   assign run      = st_r.enable && !halt_s && !stop_s;

   // ------------------------------------------------------------
   // Counter core
   // ------------------------------------------------------------
   tick_counter #(.width(tick_pkg::count_w)) u_cnt
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .run      (run),
      .clear    (cv_write),
      .reload   (st_r.reload),
      .count    (count),
      .hit_zero (hit_zero)
   );

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.ready = access;
      st_nxt.err   = access && !mapped;
      st_nxt.req   = 1'b0;
      if (rd)
      begin
         st_nxt.rdata = tick_pkg::word_zero;
         case (addr)
            tick_pkg::off_ctrl_status:
            begin
               st_nxt.rdata[tick_pkg::bit_enable]  = st_r.enable;
               st_nxt.rdata[tick_pkg::bit_tick_interrupt_enable] = st_r.tick_interrupt_enable;
               st_nxt.rdata[tick_pkg::bit_clksel]  = 1'b1;
               st_nxt.rdata[tick_pkg::bit_wrap]    = st_r.wrap_flag;
               st_nxt.wrap_flag                    = 1'b0;
            end
            tick_pkg::off_reload:
            begin
               st_nxt.rdata[tick_pkg::count_w-1:0] = st_r.reload;
            end
            tick_pkg::off_current:
            begin
               st_nxt.rdata[tick_pkg::count_w-1:0] = count;
            end
            tick_pkg::off_calib:
            begin
               st_nxt.rdata[tick_pkg::bit_no_reference_clock]   = 1'b1;
               st_nxt.rdata[tick_pkg::bit_inexact] = 1'b1;
               st_nxt.rdata[tick_pkg::count_w-1:0] = tick_pkg::calib_count;
            end
            tick_pkg::off_irq_status:
            begin
               st_nxt.rdata[tick_pkg::irq_w-1:0] = st_r.irq_stat;
            end
            tick_pkg::off_irq_mask:
            begin
               st_nxt.rdata[tick_pkg::irq_w-1:0] = st_r.irq_mask;
            end
            default:
            begin
               st_nxt.rdata = tick_pkg::word_zero;
            end
         endcase
      end
      if (wr && (pstrb[0]))
      begin
         case (addr)
            tick_pkg::off_ctrl_status:
            begin
               st_nxt.enable                = pwdata[tick_pkg::bit_enable];
               st_nxt.tick_interrupt_enable = pwdata[tick_pkg::bit_tick_interrupt_enable];
            end
            tick_pkg::off_irq_status:
            begin
               st_nxt.irq_stat = st_r.irq_stat & ~pwdata[tick_pkg::irq_w-1:0];
            end
            tick_pkg::off_irq_mask:
            begin
               st_nxt.irq_mask = pwdata[tick_pkg::irq_w-1:0];
            end
            default:
            begin
            end
         endcase
      end
      if (wr && (addr == tick_pkg::off_reload))
      begin
         if (pstrb[0])
         begin
            st_nxt.reload[7:0] = pwdata[7:0];
         end
         if (pstrb[1])
         begin
            st_nxt.reload[15:8] = pwdata[15:8];
         end
         if (pstrb[2])
         begin
            st_nxt.reload[23:16] = pwdata[23:16];
         end
      end
      if (cv_write)
      begin
         st_nxt.wrap_flag                  = 1'b0;
         st_nxt.irq_stat[tick_pkg::irq_cvwrite] = 1'b1;
      end
      if (hit_zero)
      begin
         st_nxt.wrap_flag              = 1'b1;
         st_nxt.req                    = st_r.tick_interrupt_enable;
         st_nxt.irq_stat[tick_pkg::irq_wrap] = 1'b1;
      end
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign prdata       = st_r.rdata;
   assign pready       = st_r.ready;
   assign pslverr      = st_r.err;
   assign tick_request = st_r.req;
   assign irq          = st_r.irq;
endmodule

// File: verif/tick_chk.sv
// Purpose: Port assertions for the system tick down counter
// Assumes: Ports of system_tick_down_counter, one clock
// Notes:   Shadows of reload and control follow APB writes
module tick_chk
(
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [31:0] paddr,
   input logic [31:0] pwdata,
   input logic [3:0]  pstrb,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        debug_halt,
   input logic        clock_stopped,
   input logic        tick_request,
   input logic        irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------
   // Shadow state
   // ------------------------------------------------------------
   logic [23:0] rld_r;
   logic [1:0]  ctl_r;
   logic [25:0] gap_r;
   logic        seen_r;
   logic        wr;
   logic        rd;
   assign wr = pready && pwrite;
   assign rd = pready && !pwrite;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rld_r  <= 24'h0;
         ctl_r  <= 2'h0;
         gap_r  <= 26'h0;
         seen_r <= 1'h0;
      end
      else
      begin
         if (wr && paddr[7:0] == 8'h04 && pstrb[2:0] == 3'h7)
            rld_r <= pwdata[23:0];
         if (wr && paddr[7:0] == 8'h00 && pstrb[0])
            ctl_r <= pwdata[1:0];
         gap_r  <= tick_request ? 26'h1 : gap_r + 26'h1;
         seen_r <= (seen_r | tick_request) & !wr & !debug_halt & !clock_stopped;
      end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_ready_next: assert property (s_access |=> s_answer)
      else $error("ready not one cycle after access");
   a_ready_owned: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_slverr_map: assert property (pready |-> pslverr == (paddr[7:0] > 8'h14 || paddr[1:0] != 2'h0))
      else $error("slave error on wrong address");
   a_calib_fixed: assert property (rd && paddr[7:0] == 8'h0c |-> prdata == 32'hc0000000)
      else $error("calibration word wrong");
   a_ctrl_fixed: assert property (rd && paddr[7:0] == 8'h00 |-> prdata[2] && prdata[31:17] == 15'h0
                                  && prdata[15:3] == 13'h0)
      else $error("control fixed bits wrong");
   a_count_width: assert property (rd && (paddr[7:0] == 8'h04 || paddr[7:0] == 8'h08)
                                   |-> prdata[31:24] == 8'h00)
      else $error("count upper bits set");
   a_req_gated: assert property (tick_request |-> $past(ctl_r) == 2'h3 || $past(ctl_r, 2) == 2'h3)
      else $error("request without enable");
   a_req_pulse: assert property (tick_request |=> !tick_request)
      else $error("request longer than a pulse");
   a_period_exact: assert property (tick_request && seen_r |-> gap_r == rld_r + 26'h1)
      else $error("period not reload plus one");
endmodule

bind system_tick_down_counter tick_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pstrb, .prdata, .pready, .pslverr, .debug_halt, .clock_stopped, .tick_request, .irq);

// File: verif/tb_system_tick_down_counter.sv
// Purpose: Register level test of the system tick down counter
// Assumes: APB master, answer awaited under a bound
// Notes:   Short reload values keep the run brief
module tb_system_tick_down_counter;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        debug_halt = 1'h0;
   logic        clock_stopped = 1'h0;
   logic        tick_request;
   logic        irq;
   logic [31:0] q;
   logic [31:0] p;
   logic        e;
   int          errors = 0;
   int          checked = 0;
   int          n;
   always #20 pclk = ~pclk;
   system_tick_down_counter u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .debug_halt, .clock_stopped, .tick_request, .irq);
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic close_out;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", s, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      for (i = 0; i < 20; i++)
      begin
         @(negedge pclk);
         if (pready === 1'h1)
            break;
      end
      if (i == 20)
      begin
         errors++;
         close_out();
      end
      q = prdata;
      e = pslverr;
      @(posedge pclk);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      chk($sformatf("read %h", a), x, q);
   endtask
   task automatic ticks(input int c);
      n = 0;
      repeat (c)
      begin
         @(negedge pclk);
         if (tick_request === 1'h1)
            n++;
      end
      @(posedge pclk);
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      rd(8'h00, 32'h4);
      rd(8'h0c, 32'hc0000000);
      apb(1'h0, 8'h20, 32'h0);
      chk("slverr", 32'h1, e);
      apb(1'h1, 8'h00, 32'hfffefff8);
      rd(8'h00, 32'h4);
      apb(1'h1, 8'h04, 32'hff000005);
      rd(8'h04, 32'h5);
      apb(1'h1, 8'h08, 32'h0);
      apb(1'h1, 8'h14, 32'h0);
      apb(1'h1, 8'h00, 32'h3);
      ticks(60);
      chk("period", 32'ha, n);
      chk("irq masked", 32'h0, irq);
      apb(1'h1, 8'h14, 32'h1);
      @(posedge pclk);
      chk("irq raised", 32'h1, irq);
      apb(1'h1, 8'h00, 32'h2);
      rd(8'h00, 32'h10006);
      rd(8'h00, 32'h6);
      ticks(20);
      chk("held", 32'h0, n);
      apb(1'h1, 8'h10, 32'h3);
      @(posedge pclk);
      chk("irq cleared", 32'h0, irq);
      apb(1'h1, 8'h08, 32'hffffffff);
      rd(8'h08, 32'h0);
      rd(8'h10, 32'h2);
      apb(1'h1, 8'h00, 32'h1);
      ticks(30);
      chk("no enable", 32'h0, n);
      apb(1'h1, 8'h00, 32'h0);
      rd(8'h00, 32'h10004);
      apb(1'h1, 8'h00, 32'h1);
      ticks(20);
      apb(1'h1, 8'h00, 32'h0);
      apb(1'h1, 8'h08, 32'h0);
      rd(8'h00, 32'h4);
      apb(1'h1, 8'h04, 32'h40);
      apb(1'h1, 8'h00, 32'h3);
      ticks(5);
      apb(1'h0, 8'h08, 32'h0);
      p = q;
      apb(1'h0, 8'h08, 32'h0);
      chk("live", 32'h1, q < p);
      apb(1'h1, 8'h08, 32'h0);
      ticks(50);
      chk("cv write", 32'h0, n);
      apb(1'h0, 8'h08, 32'h0);
      chk("reloaded", 32'h1, q <= 32'h40 && q > 32'h0);
      apb(1'h1, 8'h04, 32'h0);
      apb(1'h1, 8'h08, 32'h0);
      apb(1'h0, 8'h00, 32'h0);
      ticks(30);
      chk("zero reload", 32'h0, n);
      rd(8'h00, 32'h7);
      apb(1'h1, 8'h04, 32'h5);
      apb(1'h1, 8'h08, 32'h0);
      for (int k = 0; k < 2; k++)
      begin
         {clock_stopped, debug_halt} <= 2'(2'h1 << k);
         ticks(8);
         ticks(60);
         chk("stopped", 32'h0, n);
         {clock_stopped, debug_halt} <= 2'h0;
         ticks(70);
         chk("resumed", 32'h1, n > 9);
      end
      close_out();
   end
endmodule
